/* File: inc/drc_pkg.sv */
// Package: constants, field layouts and carrier types of the dancer roll loop block
package drc_pkg;
  // Clock and ramp time base
  localparam int CLK_HZ = 40_000_000;
  localparam int RAMP_UNIT_MS = 100;
  localparam int RAMP_UNIT_CYC = (CLK_HZ / 1000) * RAMP_UNIT_MS;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_IN_TYPE = 8'h04;
  localparam logic [7:0] ADDR_SET_POINT = 8'h08;
  localparam logic [7:0] ADDR_UP_LIM = 8'h0c;
  localparam logic [7:0] ADDR_LO_LIM = 8'h10;
  localparam logic [7:0] ADDR_ACC_TIME = 8'h14;
  localparam logic [7:0] ADDR_DEC_TIME = 8'h18;
  localparam logic [7:0] ADDR_GAIN = 8'h1c;
  localparam logic [7:0] ADDR_COMM_BITS = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h28;
  localparam logic [7:0] ADDR_FREQ = 8'h2c;
  localparam logic [7:0] ADDR_IN_FUNC = 8'h40;
  localparam logic [7:0] ADDR_OUT_FUNC = 8'h60;

  // Status register bit positions
  localparam int ST_MODE_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_SEL_ASSIGNED_BIT = 2;
  localparam int ST_OVER_BIT = 3;
  localparam int ST_UNDER_BIT = 4;
  localparam int ST_DIR_BIT = 5;
  localparam int ST_OC_POS = 6;

  // Terminal counts
  localparam int N_IN_TERM = 7;
  localparam int N_OUT_TERM = 3;

  // Mode and function codes
  localparam logic [7:0] MODE_MIN = 8'h28;
  localparam logic [7:0] MODE_MAX = 8'h2b;
  localparam logic [7:0] MODE_RATIO_MIN = 8'h2a;
  localparam logic [7:0] FN_NONE = 8'h00;
  localparam logic [7:0] FN_LOOP_SEL = 8'h0e;
  localparam logic [7:0] FN_UNDER = 8'h0e;
  localparam logic [7:0] FN_OVER = 8'h0f;
  localparam logic [7:0] FN_DIR = 8'h10;
  localparam logic [7:0] FN_ACTIVE = 8'h2f;
  localparam logic [7:0] FN_NEG_BASE = 8'h64;

  // Percent values in 0.1 percent steps
  localparam logic [15:0] NO_FUNC = 16'h270f;
  localparam logic [15:0] HALF_SP = 16'h01f4;
  localparam logic [15:0] PCT_FULL = 16'h03e8;

  // Feedback converter codes, full scale is 10 V or 20 mA
  localparam logic [11:0] ADC_4MA = 12'h333;
  localparam logic [11:0] ADC_SPAN_I = 12'hccc;
  localparam logic [11:0] ADC_5V = 12'h800;
  localparam logic [11:0] ADC_10V = 12'hfff;
  localparam logic [1:0] IN_TYPE_CUR = 2'h0;
  localparam logic [1:0] IN_TYPE_5V = 2'h1;

  // Speed scaling in 0.01 Hz
  localparam logic [15:0] FULL_SPEED = 16'h1770;
  localparam int GAIN_SHIFT = 4;

  // Speed source selection
  localparam logic [1:0] SRC_PANEL = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [15:0] ACC_TIME_RST = 16'h0032;
  localparam logic [15:0] GAIN_RST = 16'h0010;

  // Speed commands offered by the operation modes
  typedef struct packed {
    logic [15:0] ext;
    logic [15:0] panel;
    logic [15:0] comm;
    logic [15:0] term4;
  } drc_speed_t;

  // Software settings
  typedef struct packed {
    logic [7:0] mode;
    logic [1:0] in_type;
    logic [15:0] set_point;
    logic [15:0] up_lim;
    logic [15:0] lo_lim;
    logic [15:0] acc_time;
    logic [15:0] dec_time;
    logic [15:0] gain;
    logic [6:0] comm_bits;
    logic [6:0][7:0] in_func;
    logic [2:0][7:0] out_func;
  } drc_cfg_t;

  // Whole block state
  typedef struct packed {
    drc_cfg_t cfg;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [15:0] fb;
    logic [15:0] ramp;
    logic [39:0] acc;
    logic loop_prev;
    logic over;
    logic under;
    logic [2:0] oc;
    logic [15:0] freq;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } drc_state_t;

  localparam drc_cfg_t CFG_RST = '{
    mode: 8'h00, in_type: IN_TYPE_CUR, set_point: NO_FUNC, up_lim: NO_FUNC,
    lo_lim: NO_FUNC, acc_time: ACC_TIME_RST, dec_time: ACC_TIME_RST,
    gain: GAIN_RST, comm_bits: 7'h00, in_func: '0, out_func: '0};
  localparam drc_state_t ST_RST = '{cfg: CFG_RST, default: '0};
endpackage

/* File: rtl/drc_dancer_ctrl.sv */
// Dancer roll loop control: settings, feedback scaling, ramp, correction and status outputs
module drc_dancer_ctrl #(
  parameter int RAMP_UNIT_CYCLES = drc_pkg::RAMP_UNIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] term_pins,
  input wire logic [11:0] fb_adc,
  input wire logic [1:0] op_src,
  input wire drc_pkg::drc_speed_t speeds,
  input wire logic analog_input_select,
  input wire logic [15:0] output_freq,
  input wire logic forward_indication,
  input wire logic reverse_indication,
  output logic [15:0] freq_cmd,
  output logic [2:0] oc_on,
  output logic loop_active_flag,
  output logic feedback_over_limit_flag,
  output logic feedback_under_limit_flag,
  output logic forward_direction_output
);
  import drc_pkg::*;

  drc_state_t s_q;
  drc_state_t s_d;
  logic [6:0] term_sel;
  logic [6:0] term_on;
  logic [2:0] oc_next;
  logic dancer_mode;
  logic sel_assigned;
  logic loop_active;
  logic dir_on;
  logic wr_go;
  logic mapped;
  logic [31:0] wv;
  logic [31:0] rv;
  logic [31:0] t32;
  logic [15:0] fb_new;
  logic [15:0] target;
  logic [15:0] sp_eff;
  logic [39:0] thr;
  logic signed [16:0] err;
  logic signed [33:0] prod;
  logic signed [51:0] corr;
  logic signed [51:0] sum;

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        old[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return old;
  endfunction

  // Per input terminal: select function decode and network bit
  genvar gi;
  generate
    for (gi = 0; gi < N_IN_TERM; gi++) begin : g_in
      assign term_sel[gi] = (s_q.cfg.in_func[gi] == FN_LOOP_SEL);
      assign term_on[gi] = term_sel[gi] & (s_q.pin_s2[gi] | s_q.cfg.comm_bits[gi]);
    end
  endgenerate

  // Loop enable decision
  assign sel_assigned = |term_sel;
  assign dancer_mode = (s_q.cfg.mode >= MODE_MIN) && (s_q.cfg.mode <= MODE_MAX);
  assign loop_active = dancer_mode && (!sel_assigned || (|term_on));
  assign dir_on = forward_indication & ~reverse_indication;

  // Per output terminal: function decode and polarity
  genvar go;
  generate
    for (go = 0; go < N_OUT_TERM; go++) begin : g_out
      logic neg;
      logic [7:0] base;
      logic val;
      assign neg = (s_q.cfg.out_func[go] >= FN_NEG_BASE);
      assign base = neg ? (s_q.cfg.out_func[go] - FN_NEG_BASE) : s_q.cfg.out_func[go];
      always_comb begin
        case (base)
          FN_UNDER: val = s_q.under;
          FN_OVER: val = s_q.over;
          FN_DIR: val = dir_on;
          FN_ACTIVE: val = loop_active;
          default: val = 1'b0;
        endcase
      end
      assign oc_next[go] = (base == FN_NONE) ? 1'b0 : (val ^ neg);
    end
  endgenerate

  // AXI handshakes, gated by the clock enable so nothing is taken while frozen
  assign s_axi_awready = ce & ~s_q.aw_full & ~s_q.bvalid;
  assign s_axi_wready = ce & ~s_q.w_full & ~s_q.bvalid;
  assign s_axi_arready = ce & ~s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign wr_go = s_q.aw_full & s_q.w_full & ~s_q.bvalid;

  // Registered user outputs, except the direction output, which is combinational
  assign freq_cmd = s_q.freq;
  assign oc_on = s_q.oc;
  assign loop_active_flag = s_q.loop_prev;
  assign feedback_over_limit_flag = s_q.over;
  assign feedback_under_limit_flag = s_q.under;
  assign forward_direction_output = dir_on;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    wv = 32'h0;
    rv = 32'h0;
    mapped = 1'b0;
    t32 = 32'h0;
    thr = 40'h0;

    // Pin synchronisers
    s_d.pin_s1 = term_pins;
    s_d.pin_s2 = s_q.pin_s1;

    // Feedback scaling to 0.1 percent
    case (s_q.cfg.in_type)
      IN_TYPE_CUR: begin
        if (fb_adc > ADC_4MA) begin
          t32 = ((32'(fb_adc) - 32'(ADC_4MA)) * 32'(PCT_FULL)) / 32'(ADC_SPAN_I);
        end
      end
      IN_TYPE_5V: t32 = (32'(fb_adc) * 32'(PCT_FULL)) / 32'(ADC_5V);
      default: t32 = (32'(fb_adc) * 32'(PCT_FULL)) / 32'(ADC_10V);
    endcase
    fb_new = (t32 > 32'(PCT_FULL)) ? PCT_FULL : t32[15:0];
    s_d.fb = fb_new;

    // Limit comparisons on every update
    s_d.over = dancer_mode && (fb_new > s_q.cfg.up_lim);
    s_d.under = dancer_mode && (s_q.cfg.lo_lim != NO_FUNC) && (fb_new < s_q.cfg.lo_lim);
    s_d.oc = oc_next;

    // Main speed from the active operation mode, terminal 4 excluded in dancer mode
    case (op_src)
      SRC_PANEL: target = speeds.panel;
      SRC_COMM: target = speeds.comm;
      default: target = (analog_input_select && !dancer_mode) ? speeds.term4 : speeds.ext;
    endcase

    // Main speed ramp with the second acceleration and deceleration times
    s_d.loop_prev = loop_active;
    if (!loop_active) begin
      s_d.ramp = target;
      s_d.acc = 40'h0;
    end else if (!s_q.loop_prev) begin
      s_d.ramp = output_freq;
      s_d.acc = 40'h0;
    end else if (target != s_q.ramp) begin
      thr = (target > s_q.ramp) ? 40'(s_q.cfg.acc_time) * 40'(RAMP_UNIT_CYCLES)
                                : 40'(s_q.cfg.dec_time) * 40'(RAMP_UNIT_CYCLES);
      if (thr == 40'h0) begin
        s_d.ramp = target;
      end else if (s_q.acc + 40'(FULL_SPEED) >= thr) begin
        s_d.acc = s_q.acc + 40'(FULL_SPEED) - thr;
        s_d.ramp = (target > s_q.ramp) ? s_q.ramp + 16'h1 : s_q.ramp - 16'h1;
      end else begin
        s_d.acc = s_q.acc + 40'(FULL_SPEED);
      end
    end

    // Loop correction from set point and feedback
    sp_eff = (s_q.cfg.set_point == NO_FUNC) ? HALF_SP : s_q.cfg.set_point;
    err = $signed({1'b0, sp_eff}) - $signed({1'b0, s_q.fb});
    if (s_q.cfg.mode[0]) begin
      err = -err;
    end
    prod = err * $signed({1'b0, s_q.cfg.gain});
    corr = 52'(prod >>> GAIN_SHIFT);
    if (s_q.cfg.mode >= MODE_RATIO_MIN) begin
      corr = (corr * 52'($signed({1'b0, s_q.ramp}))) / 52'($signed({1'b0, FULL_SPEED}));
    end
    sum = 52'($signed({1'b0, s_q.ramp})) + corr;
    if (!s_q.loop_prev) begin
      s_d.freq = target;
    end else if (sum < 0) begin
      s_d.freq = 16'h0;
    end else if (sum > 52'sd65535) begin
      s_d.freq = 16'hffff;
    end else begin
      s_d.freq = sum[15:0];
    end

    // Write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register write once address and data are both held
    if (wr_go) begin
      mapped = 1'b1;
      case (s_q.aw_addr)
        ADDR_MODE: begin
          wv = merge(32'(s_q.cfg.mode), s_q.w_data, s_q.w_strb);
          s_d.cfg.mode = wv[7:0];
        end
        ADDR_IN_TYPE: begin
          wv = merge(32'(s_q.cfg.in_type), s_q.w_data, s_q.w_strb);
          s_d.cfg.in_type = wv[1:0];
        end
        ADDR_SET_POINT: begin
          wv = merge(32'(s_q.cfg.set_point), s_q.w_data, s_q.w_strb);
          s_d.cfg.set_point = wv[15:0];
        end
        ADDR_UP_LIM: begin
          wv = merge(32'(s_q.cfg.up_lim), s_q.w_data, s_q.w_strb);
          s_d.cfg.up_lim = wv[15:0];
        end
        ADDR_LO_LIM: begin
          wv = merge(32'(s_q.cfg.lo_lim), s_q.w_data, s_q.w_strb);
          s_d.cfg.lo_lim = wv[15:0];
        end
        ADDR_ACC_TIME: begin
          wv = merge(32'(s_q.cfg.acc_time), s_q.w_data, s_q.w_strb);
          s_d.cfg.acc_time = wv[15:0];
        end
        ADDR_DEC_TIME: begin
          wv = merge(32'(s_q.cfg.dec_time), s_q.w_data, s_q.w_strb);
          s_d.cfg.dec_time = wv[15:0];
        end
        ADDR_GAIN: begin
          wv = merge(32'(s_q.cfg.gain), s_q.w_data, s_q.w_strb);
          s_d.cfg.gain = wv[15:0];
        end
        ADDR_COMM_BITS: begin
          wv = merge(32'(s_q.cfg.comm_bits), s_q.w_data, s_q.w_strb);
          s_d.cfg.comm_bits = wv[6:0];
        end
        ADDR_STATUS, ADDR_FEEDBACK, ADDR_FREQ: mapped = 1'b1;
        default: begin
          mapped = 1'b0;
          for (int i = 0; i < N_IN_TERM; i++) begin
            if (s_q.aw_addr == ADDR_IN_FUNC + 8'(4 * i)) begin
              wv = merge(32'(s_q.cfg.in_func[i]), s_q.w_data, s_q.w_strb);
              s_d.cfg.in_func[i] = wv[7:0];
              mapped = 1'b1;
            end
          end
          for (int i = 0; i < N_OUT_TERM; i++) begin
            if (s_q.aw_addr == ADDR_OUT_FUNC + 8'(4 * i)) begin
              wv = merge(32'(s_q.cfg.out_func[i]), s_q.w_data, s_q.w_strb);
              s_d.cfg.out_func[i] = wv[7:0];
              mapped = 1'b1;
            end
          end
        end
      endcase
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      mapped = 1'b1;
      case (s_axi_araddr)
        ADDR_MODE: rv = 32'(s_q.cfg.mode);
        ADDR_IN_TYPE: rv = 32'(s_q.cfg.in_type);
        ADDR_SET_POINT: rv = 32'(s_q.cfg.set_point);
        ADDR_UP_LIM: rv = 32'(s_q.cfg.up_lim);
        ADDR_LO_LIM: rv = 32'(s_q.cfg.lo_lim);
        ADDR_ACC_TIME: rv = 32'(s_q.cfg.acc_time);
        ADDR_DEC_TIME: rv = 32'(s_q.cfg.dec_time);
        ADDR_GAIN: rv = 32'(s_q.cfg.gain);
        ADDR_COMM_BITS: rv = 32'(s_q.cfg.comm_bits);
        ADDR_STATUS: begin
          rv[ST_MODE_BIT] = dancer_mode;
          rv[ST_ACTIVE_BIT] = s_q.loop_prev;
          rv[ST_SEL_ASSIGNED_BIT] = sel_assigned;
          rv[ST_OVER_BIT] = s_q.over;
          rv[ST_UNDER_BIT] = s_q.under;
          rv[ST_DIR_BIT] = dir_on;
          rv[ST_OC_POS +: 3] = s_q.oc;
        end
        ADDR_FEEDBACK: rv = 32'(s_q.fb);
        ADDR_FREQ: rv = {s_q.ramp, s_q.freq};
        default: begin
          mapped = 1'b0;
          for (int i = 0; i < N_IN_TERM; i++) begin
            if (s_axi_araddr == ADDR_IN_FUNC + 8'(4 * i)) begin
              rv = 32'(s_q.cfg.in_func[i]);
              mapped = 1'b1;
            end
          end
          for (int i = 0; i < N_OUT_TERM; i++) begin
            if (s_axi_araddr == ADDR_OUT_FUNC + 8'(4 * i)) begin
              rv = 32'(s_q.cfg.out_func[i]);
              mapped = 1'b1;
            end
          end
        end
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata = rv;
      s_d.rresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= ST_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

/* File: test/drc_dancer_ctrl_assertions.sv */
// Checker for handshake, freeze and direction relations at the block ports
module drc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic forward_indication,
  input wire logic reverse_indication,
  input wire logic forward_direction_output,
  input wire logic feedback_over_limit_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Direction output, bus answers and clock enable freeze
  AST_DIR_FWD: assert property (forward_direction_output == (forward_indication && !reverse_indication))
    else $error("direction output wrong");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_WR_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  AST_CE_STALL: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus ready while stalled");
  AST_CE_FREEZE: assert property (!ce |=> $stable(feedback_over_limit_flag))
    else $error("flag moved while stalled");
endmodule

bind drc_dancer_ctrl drc_checker u_drc_checker (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .forward_indication(forward_indication), .reverse_indication(reverse_indication),
  .forward_direction_output(forward_direction_output),
  .feedback_over_limit_flag(feedback_over_limit_flag));

/* File: test/drc_dancer_ctrl_test.sv */
// Self-checking bench of the dancer roll loop block
module drc_dancer_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import drc_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, loop_active_flag, feedback_over_limit_flag, feedback_under_limit_flag;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_src = 0, fb_type = 0;
  logic [6:0] term_pins = 0;
  logic [11:0] fb_adc;
  logic [9:0] fb_pct = 0;
  drc_speed_t speeds = '0;
  logic analog_input_select = 0, forward_indication = 0, reverse_indication = 0;
  logic forward_direction_output;
  logic [15:0] output_freq = 0, freq_cmd;
  logic [2:0] oc_on;
  int bad_count = 0, total_checks = 0, cyc = 0, seed = 32'hab73bd3e;
  int spd[4];
  int modes[7] = '{0, 39, 40, 41, 42, 43, 44};
  int pcts[3] = '{800, 200, 500};

  initial forever #12.5 aclk = ~aclk;

  drc_fb_source u_drc_fb_source (.aclk(aclk), .in_type(fb_type), .pct(fb_pct), .fb_adc(fb_adc));

  drc_dancer_ctrl #(.RAMP_UNIT_CYCLES(10)) u_drc_dancer_ctrl (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .term_pins(term_pins), .fb_adc(fb_adc), .op_src(op_src), .speeds(speeds),
    .analog_input_select(analog_input_select), .output_freq(output_freq),
    .forward_indication(forward_indication), .reverse_indication(reverse_indication),
    .freq_cmd(freq_cmd), .oc_on(oc_on), .loop_active_flag(loop_active_flag),
    .feedback_over_limit_flag(feedback_over_limit_flag),
    .feedback_under_limit_flag(feedback_under_limit_flag),
    .forward_direction_output(forward_direction_output));

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write, both channels offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Readies are combinational: look at them before the edge that takes
    forever begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  // Bus read, compared with the expected word and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] rd;
    logic [1:0] rr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) break;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", e, rd);
    chk("rresp", er, rr);
  endtask

  // Reference scaling of the converter code to 0.1 percent
  function automatic int fb_exp(int t, int c);
    if (t == 2) return c * 1000 / 4095;
    if (t == 1) return c >= 2048 ? 1000 : c * 1000 / 2048;
    return c < 819 ? 0 : (c - 819) * 1000 / 3276;
  endfunction

  // Cycle ceiling against a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and refused places
    rc(ADDR_MODE, 0, RESP_OKAY);
    rc(ADDR_SET_POINT, 32'(NO_FUNC), RESP_OKAY);
    rc(ADDR_LO_LIM, 32'(NO_FUNC), RESP_OKAY);
    rc(ADDR_ACC_TIME, 32'(ACC_TIME_RST), RESP_OKAY);
    rc(8'h3c, 0, RESP_SLVERR);
    wr(8'h3c, 1, RESP_SLVERR);
    // Feedback scaling for every input type
    for (int t = 0; t < 3; t++) begin
      wr(ADDR_IN_TYPE, t, RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
        fb_type <= 2'(t);
        fb_pct <= (t == 2) ? 10'($unsigned($random(seed)) % 1001) : 10'(k % 3 * 500);
        repeat (5) @(posedge aclk);
        rc(ADDR_FEEDBACK, 32'(fb_exp(t, int'(fb_adc))), RESP_OKAY);
      end
    end
    // Mode selection with no select terminal
    foreach (modes[i]) begin
      wr(ADDR_MODE, modes[i], RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("loop mode", modes[i] inside {[40:43]}, loop_active_flag);
    end
    wr(ADDR_MODE, 41, RESP_OKAY);
    // Select terminal from pin and from the network bit
    wr(ADDR_IN_FUNC + 8'h08, FN_LOOP_SEL, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("sel off", 0, loop_active_flag);
    term_pins <= 7'h04 | (7'($random(seed)) & 7'h7b);
    repeat (5) @(posedge aclk);
    chk("sel pin", 1, loop_active_flag);
    term_pins <= 7'h00;
    wr(ADDR_COMM_BITS, 32'h4, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("sel net", 1, loop_active_flag);
    // Main speed per operation mode, terminal 4 refused in dancer mode
    wr(ADDR_GAIN, 0, RESP_OKAY);
    wr(ADDR_ACC_TIME, 0, RESP_OKAY);
    wr(ADDR_DEC_TIME, 0, RESP_OKAY);
    analog_input_select <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      foreach (spd[j]) spd[j] = $unsigned($random(seed)) % 60000;
      op_src <= 2'(s);
      speeds <= '{16'(spd[0]), 16'(spd[1]), 16'(spd[2]), 16'(spd[3])};
      repeat (5) @(posedge aclk);
      chk("freq dancer", spd[s], freq_cmd);
    end
    op_src <= 2'h0;
    wr(ADDR_COMM_BITS, 0, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("freq off sel", spd[0], freq_cmd);
    wr(ADDR_MODE, 0, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("freq normal", spd[3], freq_cmd);
    wr(ADDR_MODE, 41, RESP_OKAY);
    // Output frequency adopted on select, then ramp with second times
    analog_input_select <= 1'b0;
    output_freq <= 16'd1000;
    speeds.ext <= 16'd7000;
    wr(ADDR_ACC_TIME, 1000, RESP_OKAY);
    wr(ADDR_COMM_BITS, 4, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("adopt", 1, freq_cmd >= 992 && freq_cmd <= 1008);
    repeat (200) @(posedge aclk);
    chk("ramp", 1, freq_cmd > 1008 && freq_cmd < 7000);
    wr(ADDR_COMM_BITS, 0, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("sel end", 7000, freq_cmd);
    // Limit flags and terminal polarity
    wr(ADDR_COMM_BITS, 4, RESP_OKAY);
    wr(ADDR_UP_LIM, 600, RESP_OKAY);
    wr(ADDR_LO_LIM, 400, RESP_OKAY);
    wr(ADDR_OUT_FUNC, FN_OVER, RESP_OKAY);
    wr(ADDR_OUT_FUNC + 8'h04, FN_UNDER + FN_NEG_BASE, RESP_OKAY);
    wr(ADDR_OUT_FUNC + 8'h08, FN_ACTIVE, RESP_OKAY);
    foreach (pcts[i]) begin
      fb_pct <= 10'(pcts[i]);
      repeat (5) @(posedge aclk);
      chk("over", i == 0, feedback_over_limit_flag);
      chk("under", i == 1, feedback_under_limit_flag);
      chk("oc", {1'b1, i != 1, i == 0}, oc_on);
    end
    ce <= 1'b0;
    fb_pct <= 10'd900;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    wr(ADDR_OUT_FUNC + 8'h08, FN_ACTIVE + FN_NEG_BASE, RESP_OKAY);
    fb_pct <= 10'd200;
    wr(ADDR_LO_LIM, 32'(NO_FUNC), RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("under off", 0, feedback_under_limit_flag);
    chk("oc neg", 3'b010, oc_on);
    // Direction output for every indication pair
    wr(ADDR_OUT_FUNC + 8'h08, FN_DIR, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      forward_indication <= k[0];
      reverse_indication <= k[1];
      repeat (3) @(posedge aclk);
      chk("dir", k == 1, forward_direction_output);
      chk("dir oc", k == 1, oc_on[2]);
    end
    end_of_test();
  end
endmodule

/* File: test/drc_fb_source.sv */
// Roller position detector model driving the feedback converter code
module drc_fb_source (
  input wire logic aclk,
  input wire logic [1:0] in_type,
  input wire logic [9:0] pct,
  output logic [11:0] fb_adc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial fb_adc = '0;
  // Position in 0.1 percent turned into the code of the chosen range
  always @(posedge aclk) begin
    case (in_type)
      2'h0: fb_adc <= 12'(819 + int'(pct) * 3276 / 1000);
      2'h1: fb_adc <= 12'(int'(pct) * 2048 / 1000);
      default: fb_adc <= 12'(int'(pct) * 4095 / 1000);
    endcase
  end
endmodule
